// ===== logic/dtr_osc_counter.sv
// Saturating counter of replica clock tree passes
`timescale 1ns/10ps
module dtr_osc_counter
	import dtr_pkg::*;
#(
	parameter int WIDTH = DTR_CNT_W
) (
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic             osc_tick,
	input  wire logic             run,
	input  wire logic             clear,
	output logic      [WIDTH-1:0] count
);

	logic tick_s1_r;
	logic tick_s2_r;
	logic tick_s3_r;
	logic step;

	if (WIDTH < 2) begin : g_chk
		$error("dtr_osc_counter: WIDTH too small");
	end

	// Ring output toggles once per pass; it is asynchronous to core_clk
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tick_s1_r <= 1'b0;
			tick_s2_r <= 1'b0;
			tick_s3_r <= 1'b0;
		end else begin
			tick_s1_r <= osc_tick;
			tick_s2_r <= tick_s1_r;
			tick_s3_r <= tick_s2_r;
		end
	end

	assign step = tick_s2_r ^ tick_s3_r;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			count <= '0;
		end else if (clear) begin
			count <= '0; // RL16
		end else if (run && step && (count != {WIDTH{1'b1}})) begin
			count <= count + 1'b1; // RL16 RL14
		end
	end

endmodule : dtr_osc_counter

// ===== logic/dtr_status_readout.sv
// Oscillator count and temperature status readout with AHB-Lite register slave
`timescale 1ns/10ps
module dtr_status_readout
	import dtr_pkg::*;
#(
	parameter int TSI_CYC = DTR_TSI_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        osc_tick,
	input  wire logic [2:0]  temp_raw,
	input  wire logic        lp_exit,
	output logic      [1:0]  temp_compensated_self_refresh_offset,
	output logic             irq
);

	if (TSI_CYC < 4) begin : g_chk
		$error("dtr_status_readout: TSI_CYC too small");
	end

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	logic [7:0]            addr_q_r;
	logic                  wr_q_r;
	logic                  wr_en;
	logic                  rd_acc;
	logic [31:0]           rd_val;
	logic                  start_cmd;
	logic                  stop_cmd;
	logic                  ofs_wr;

	logic                  run_r;
	logic                  pend_r;
	logic [7:0]            dly_cnt_r;
	logic [7:0]            rt_r;
	logic [7:0]            rt_cnt_r;
	logic [7:0]            cnt_lo_r;
	logic [7:0]            cnt_hi_r;
	logic [DTR_CNT_W-1:0]  cnt;
	logic                  start_acc;
	logic                  auto_stop;
	logic                  man_stop;
	logic                  stop_evt;
	logic                  osc_done;

	logic [2:0]            tr_s1_r;
	logic [2:0]            tr_s2_r;
	logic                  lp_s1_r;
	logic                  lp_s2_r;
	logic                  lp_s3_r;
	logic                  lp_edge;
	logic [31:0]           tsi_cnt_r;
	logic                  tsi_wrap;
	logic                  ofs_pend_r;
	logic                  temp_upd;
	logic [2:0]            temp_code_r;
	logic [1:0]            ofs_r;

	logic [DTR_IRQ_W-1:0]  irq_stat_r;
	logic [DTR_IRQ_W-1:0]  irq_mask_r;
	logic [DTR_IRQ_W-1:0]  irq_evt;

	// Sensor plus offset, clipped at the top code
	function automatic logic [2:0] adj_code(input logic [2:0] raw, input logic [1:0] ofs);
		logic [3:0] sum;
		sum = {1'b0, raw} + {2'b00, ofs};
		adj_code = sum[3] ? DTR_TEMP_MAX : sum[2:0];
	endfunction : adj_code

	// Zero wait state: read data is fetched in the address phase
	assign rd_acc = hsel && htrans[1] && hready && !hwrite;
	assign wr_en  = wr_q_r;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			addr_q_r <= 8'h00;
			wr_q_r   <= 1'b0;
		end else if (hready) begin
			addr_q_r <= haddr[7:0];
			wr_q_r   <= hsel && htrans[1] && hwrite && (haddr[31:8] == 24'h00_0000);
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		if (haddr[31:8] != 24'h00_0000) begin
			rd_val = 32'h0000_0000;
		end else if (haddr[7:0] == DTR_OFS_RUNTIME) begin
			rd_val[7:0] = rt_r;
		end else if (haddr[7:0] == DTR_OFS_CNT_LO) begin
			rd_val[7:0] = cnt_lo_r;
		end else if (haddr[7:0] == DTR_OFS_CNT_HI) begin
			rd_val[7:0] = cnt_hi_r;
		end else if (haddr[7:0] == DTR_OFS_TEMP) begin
			rd_val[DTR_TEMP_CODE_LSB +: 3] = temp_code_r; // RL12
			rd_val[DTR_TEMP_OFS_LSB +: 2]  = ofs_r;
		end else if (haddr[7:0] == DTR_OFS_STATUS) begin
			rd_val[DTR_ST_RUN]  = run_r;
			rd_val[DTR_ST_PEND] = pend_r;
		end else if (haddr[7:0] == DTR_OFS_IRQ_STAT) begin
			rd_val[DTR_IRQ_W-1:0] = irq_stat_r;
		end else if (haddr[7:0] == DTR_OFS_IRQ_MASK) begin
			rd_val[DTR_IRQ_W-1:0] = irq_mask_r;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (rd_acc) begin
				hrdata <= rd_val;
			end
		end
	end

	assign start_cmd = wr_en && (addr_q_r == DTR_OFS_CTRL) && hwdata[DTR_CTRL_START];
	assign stop_cmd  = wr_en && (addr_q_r == DTR_OFS_CTRL) && hwdata[DTR_CTRL_STOP];
	assign ofs_wr    = wr_en && (addr_q_r == DTR_OFS_TEMP);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rt_r <= DTR_RUNTIME_RST;
		end else if (wr_en && (addr_q_r == DTR_OFS_RUNTIME)) begin
			rt_r <= hwdata[7:0];
		end
	end

	// ****************************************************************
	// Interval oscillator
	// ****************************************************************
	// A start during the readout delay is refused so the pending count survives
	assign start_acc = start_cmd && !run_r && !pend_r; // RL2
	assign auto_stop = run_r && (rt_r != 8'h00) && (rt_cnt_r == rt_r - 8'h01); // RL4
	// Explicit stop only counts in manual mode; otherwise it is illegal
	assign man_stop  = run_r && stop_cmd && (rt_r == 8'h00); // RL3 RL15
	assign stop_evt  = auto_stop || man_stop;
	assign osc_done  = pend_r && (dly_cnt_r == 8'(DTR_OSCO_CYC - 1));

	always_ff @(posedge core_clk) begin
		if (srst) begin
			run_r    <= 1'b0;
			rt_cnt_r <= 8'h00;
		end else if (start_acc) begin
			run_r    <= 1'b1;
			rt_cnt_r <= 8'h00;
		end else if (stop_evt) begin
			run_r    <= 1'b0; // RL3 RL4
		end else if (run_r) begin
			rt_cnt_r <= rt_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pend_r    <= 1'b0;
			dly_cnt_r <= 8'h00;
		end else if (stop_evt) begin
			pend_r    <= 1'b1;
			dly_cnt_r <= 8'h00;
		end else if (osc_done) begin
			pend_r    <= 1'b0; // RL1
		end else if (pend_r) begin
			dly_cnt_r <= dly_cnt_r + 8'h01;
		end
	end

	// Published only after the readout delay, overwriting the last result
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt_lo_r <= 8'h00;
			cnt_hi_r <= 8'h00;
		end else if (osc_done) begin
			cnt_lo_r <= cnt[7:0];  // RL13 RL1
			cnt_hi_r <= cnt[15:8]; // RL13
		end
	end

	dtr_osc_counter #(
		.WIDTH (DTR_CNT_W)
	) u_cnt (
		.core_clk (core_clk),
		.srst     (srst),
		.osc_tick (osc_tick),
		.run      (run_r),
		.clear    (start_acc),
		.count    (cnt)
	);

	// ****************************************************************
	// Temperature sensor
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tr_s1_r <= 3'h0;
			tr_s2_r <= 3'h0;
			lp_s1_r <= 1'b0;
			lp_s2_r <= 1'b0;
			lp_s3_r <= 1'b0;
		end else begin
			tr_s1_r <= temp_raw;
			tr_s2_r <= tr_s1_r;
			lp_s1_r <= lp_exit;
			lp_s2_r <= lp_s1_r;
			lp_s3_r <= lp_s2_r;
		end
	end

	assign lp_edge  = lp_s2_r && !lp_s3_r;
	assign tsi_wrap = (tsi_cnt_r == 32'(TSI_CYC - 1));
	// Exit from a low-power state forces a fresh sample
	assign temp_upd = tsi_wrap || ofs_pend_r || lp_edge; // RL8 RL9 RL10

	always_ff @(posedge core_clk) begin
		if (srst || temp_upd) begin
			tsi_cnt_r <= 32'h0000_0000; // RL8
		end else begin
			tsi_cnt_r <= tsi_cnt_r + 32'h0000_0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ofs_r       <= 2'h0;
			ofs_pend_r  <= 1'b0;
			temp_compensated_self_refresh_offset <= 2'h0;
		end else begin
			ofs_pend_r  <= ofs_wr; // RL7
			temp_compensated_self_refresh_offset <= ofs_r;  // RL6
			if (ofs_wr) begin
				ofs_r <= hwdata[DTR_TEMP_OFS_LSB +: 2]; // RL6
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			temp_code_r <= DTR_TEMP_RST;
		end else if (temp_upd) begin
			temp_code_r <= adj_code(tr_s2_r, ofs_r); // RL7 RL12
		end
	end

	// ****************************************************************
	// Interrupts
	// ****************************************************************
	always_comb begin
		irq_evt                  = '0;
		irq_evt[DTR_IRQ_DONE]    = osc_done;
		irq_evt[DTR_IRQ_TEMP]    = temp_upd;
		irq_evt[DTR_IRQ_REFUSED] = start_cmd && !start_acc;
		irq_evt[DTR_IRQ_ILLEGAL] = stop_cmd && (rt_r != 8'h00);
	end

	// New events win over a write-one clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			irq        <= 1'b0;
		end else begin
			if (wr_en && (addr_q_r == DTR_OFS_IRQ_STAT)) begin
				irq_stat_r <= (irq_stat_r & ~hwdata[DTR_IRQ_W-1:0]) | irq_evt;
			end else begin
				irq_stat_r <= irq_stat_r | irq_evt;
			end
			if (wr_en && (addr_q_r == DTR_OFS_IRQ_MASK)) begin
				irq_mask_r <= hwdata[DTR_IRQ_W-1:0];
			end
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_osco_delay;
		@(posedge core_clk) disable iff (srst)
		stop_evt |=> (!osc_done)[*7] ##1 osc_done;
	endproperty
	a_osco_delay: assert property (p_osco_delay) else $error("count published too early"); // RL1

	property p_manual_hold;
		@(posedge core_clk) disable iff (srst)
		run_r && (rt_r == 8'h00) && !stop_cmd |=> run_r;
	endproperty
	a_manual_hold: assert property (p_manual_hold) else $error("manual run stopped itself"); // RL3

	property p_auto_stop;
		@(posedge core_clk) disable iff (srst)
		run_r && (rt_r != 8'h00) |-> (rt_cnt_r < rt_r);
	endproperty
	a_auto_stop: assert property (p_auto_stop) else $error("auto stop overran run time"); // RL4

	property p_auto_hold;
		@(posedge core_clk) disable iff (srst)
		run_r && (rt_r != 8'h00) && (rt_cnt_r < rt_r - 8'h01) |=> run_r;
	endproperty
	a_auto_hold: assert property (p_auto_hold) else $error("auto stop came early"); // RL4

	property p_clear_on_start;
		@(posedge core_clk) disable iff (srst)
		start_acc |=> (cnt == 16'h0000) && run_r;
	endproperty
	a_clear_on_start: assert property (p_clear_on_start) else $error("count not cleared"); // RL16

	property p_saturate;
		@(posedge core_clk) disable iff (srst)
		(cnt == 16'hFFFF) && !start_acc |=> (cnt == 16'hFFFF);
	endproperty
	a_saturate: assert property (p_saturate) else $error("counter wrapped"); // RL14

	property p_split;
		@(posedge core_clk) disable iff (srst)
		osc_done |=> (cnt_lo_r == $past(cnt[7:0])) && (cnt_hi_r == $past(cnt[15:8]));
	endproperty
	a_split: assert property (p_split) else $error("count bytes misplaced"); // RL13

	property p_offset_seen;
		@(posedge core_clk) disable iff (srst)
		ofs_wr |=> ##1 (temp_code_r == adj_code($past(tr_s2_r), ofs_r));
	endproperty
	a_offset_seen: assert property (p_offset_seen) else $error("offset not reflected"); // RL7

	property p_tsi_period;
		@(posedge core_clk) disable iff (srst)
		tsi_cnt_r < 32'(TSI_CYC);
	endproperty
	a_tsi_period: assert property (p_tsi_period) else $error("sample interval exceeded"); // RL8

	property p_lp_fresh;
		@(posedge core_clk) disable iff (srst)
		$rose(lp_s2_r) |-> temp_upd ##1 (tsi_cnt_r == 32'h0000_0000);
	endproperty
	a_lp_fresh: assert property (p_lp_fresh) else $error("no sample on low-power exit"); // RL9

	c_auto: cover property (@(posedge core_clk) disable iff (srst) auto_stop ##8 osc_done);
	c_manual: cover property (@(posedge core_clk) disable iff (srst) man_stop);
	c_overflow: cover property (@(posedge core_clk) disable iff (srst) osc_done && (&cnt));
	c_offset: cover property (@(posedge core_clk) disable iff (srst) ofs_wr ##2 irq);

	// hsize is accepted but ignored; every transfer is served as a whole word
	logic unused_hsize;
	assign unused_hsize = ^hsize;

endmodule : dtr_status_readout

// ===== shared/dtr_pkg.sv
// Package: constants for the interval oscillator and temperature status readout
//
// Notes on behaviour
// [RL1] Count readable only after stop-to-readout delay
// [RL2] Controller waits out readout delay before restarting
// [RL3] Run-time zero: runs until explicit stop
// [RL4] Run-time nonzero: stops itself after programmed clocks
// [RL5] Controller runs oscillator at least 200 ns
// [RL6] Thermal offset adjusts this channel's refresh rate
// [RL7] Offset shows in temperature field within 200 us
// [RL8] Temperature sampled at least every 32 ms
// [RL9] Status fresh on self refresh or power-down exit
// [RL10] Update early enough for 2 degree margin
// [RL11] Controller polls status often enough for margin
// [RL12] Three-bit code; 011 means possibly above 85 C
// [RL13] Stop stores count as low and high byte
// [RL14] Counter saturates; maximum value means overflow
// [RL15] No explicit stop when auto stop programmed
// [RL16] Counter counts tree passes, clears on start
package dtr_pkg;

	// ****************************************************************
	// Register offsets (byte addresses)
	// ****************************************************************
	localparam logic [7:0] DTR_OFS_CTRL      = 8'h00;
	localparam logic [7:0] DTR_OFS_RUNTIME   = 8'h04;
	localparam logic [7:0] DTR_OFS_CNT_LO    = 8'h08;
	localparam logic [7:0] DTR_OFS_CNT_HI    = 8'h0C;
	localparam logic [7:0] DTR_OFS_TEMP      = 8'h10;
	localparam logic [7:0] DTR_OFS_STATUS    = 8'h14;
	localparam logic [7:0] DTR_OFS_IRQ_STAT  = 8'h18;
	localparam logic [7:0] DTR_OFS_IRQ_MASK  = 8'h1C;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int DTR_CTRL_START   = 0;
	localparam int DTR_CTRL_STOP    = 1;
	localparam int DTR_TEMP_CODE_LSB = 0;
	localparam int DTR_TEMP_OFS_LSB = 5;
	localparam int DTR_ST_RUN       = 0;
	localparam int DTR_ST_PEND      = 1;
	localparam int DTR_IRQ_DONE     = 0;
	localparam int DTR_IRQ_TEMP     = 1;
	localparam int DTR_IRQ_REFUSED  = 2;
	localparam int DTR_IRQ_ILLEGAL  = 3;
	localparam int DTR_IRQ_W        = 4;
	localparam int DTR_CNT_W        = 16;

	// ****************************************************************
	// Reset values and codes
	// ****************************************************************
	localparam logic [2:0] DTR_TEMP_RST   = 3'h3;
	localparam logic [2:0] DTR_TEMP_HOT   = 3'h3;
	localparam logic [2:0] DTR_TEMP_MAX   = 3'h7;
	localparam logic [7:0] DTR_RUNTIME_RST = 8'h00;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int DTR_CLK_PS     = 5000;
	localparam int DTR_OSCO_NS    = 40;
	localparam int DTR_OSCO_NCK   = 8;
	localparam int DTR_OSCO_NS_CYC = (DTR_OSCO_NS * 1000 + DTR_CLK_PS - 1) / DTR_CLK_PS;
	localparam int DTR_OSCO_CYC   = (DTR_OSCO_NS_CYC > DTR_OSCO_NCK) ? DTR_OSCO_NS_CYC
	                                                                 : DTR_OSCO_NCK;
	localparam int DTR_TSI_MS     = 32;
	localparam int DTR_TSI_CYC    = (DTR_TSI_MS * 1000000) / (DTR_CLK_PS / 1000);

endpackage : dtr_pkg

// ===== tb/dtr_ctrl_model.sv
// Controller-side bus master that issues register commands and reads
`timescale 1ns/10ps
module dtr_ctrl_model
	import dtr_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	initial begin
		hsel   = 1'b0;
		haddr  = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0;
	end

	// ****************************************************************
	// Single word transfer
	// ****************************************************************
	// No latency assumed: both phases wait for hready; the bench watchdog ends a hang
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= 3'h2;
		hwdata <= ~hwdata;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		haddr  <= ~a;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
		q = hrdata;
	endtask : xfer
endmodule : dtr_ctrl_model

// ===== tb/tb_dqs_osc_and_temp_status_readout.sv
// Self-checking bench for the oscillator count and temperature status readout
`timescale 1ns/10ps
module tb_dqs_osc_and_temp_status_readout
	import dtr_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        srst     = 1'b1;
	logic        osc_tick = 1'b0;
	logic [1:0]  tdiv     = 2'h0;
	logic [2:0]  temp_raw = 3'h3;
	logic        lp_exit  = 1'b0;
	logic        hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans, temp_compensated_self_refresh_offset;
	logic [2:0]  hsize, raw;
	int          fails = 0, cmp_count = 0, rt, j;

	always #2.5 core_clk = ~core_clk;

	// Replica tree output toggles every 4 clocks, slower than the sync limit
	always @(posedge core_clk) begin
		tdiv <= tdiv + 2'h1;
		if (tdiv == 2'h3) osc_tick <= ~osc_tick;
	end

	dtr_ctrl_model u_dtr_ctrl_model (.core_clk(core_clk), .hready(hreadyout),
		.hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	dtr_status_readout #(.TSI_CYC(64)) u_dtr_status_readout (.core_clk(core_clk),
		.srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .osc_tick(osc_tick),
		.temp_raw(temp_raw), .lp_exit(lp_exit), .temp_compensated_self_refresh_offset(temp_compensated_self_refresh_offset), .irq(irq));

	// ****************************************************************
	// Bus access, comparison and expectation helpers
	// ****************************************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		u_dtr_ctrl_model.xfer(1'b1, {24'h0, a}, d, x);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		u_dtr_ctrl_model.xfer(1'b0, {24'h0, a}, 32'h0, d);
	endtask : rd

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Tree passes are counted after a synchroniser, so phase allows one either way
	task automatic chk_cnt(input int len);
		logic [31:0] lo, hi;
		int          e;
		rd(DTR_OFS_CNT_LO, lo);
		rd(DTR_OFS_CNT_HI, hi);
		e = len / 4;
		cmp_count++;
		if ($isunknown({hi[7:0], lo[7:0]}) || int'({hi[7:0], lo[7:0]}) > e + 1 ||
			int'({hi[7:0], lo[7:0]}) < e - 1) begin
			fails++;
			$display("unexpected count expected %0d seen %h", e, {hi[7:0], lo[7:0]});
		end
	endtask : chk_cnt

	function automatic logic [31:0] exp_temp(input logic [2:0] r, input logic [1:0] k);
		logic [3:0] s;
		s = {1'b0, r} + {2'b0, k};
		return {25'h0, k, 2'b0, (s > 4'h7) ? 3'h7 : s[2:0]};
	endfunction : exp_temp

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (6000) @(posedge core_clk);
		fails++;
		end_of_test();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		void'($urandom(32'h35d9b5e3));
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		for (j = 0; j < 8; j++) begin
			rd(8'(j * 4), q);
			chk("reset value", (j == 4) ? 32'h3 : 32'h0, q);
		end
		rt = 40 + int'($urandom % 40);
		wr(DTR_OFS_RUNTIME, 32'(rt));
		rd(DTR_OFS_RUNTIME, q);
		chk("runtime", 32'(rt), q);
		wr(DTR_OFS_IRQ_MASK, 32'hD);
		// Auto stop, readout held back, start refused while pending
		wr(DTR_OFS_CTRL, 32'h1);
		repeat (rt - 1) @(posedge core_clk);
		wr(DTR_OFS_CTRL, 32'h1);
		rd(DTR_OFS_STATUS, q);
		chk("status pending", 32'h2, q);
		rd(DTR_OFS_CNT_LO, q);
		chk("early count", 32'h0, q);
		repeat (12) @(posedge core_clk);
		chk_cnt(rt);
		rd(DTR_OFS_IRQ_STAT, q);
		chk("refused start", 32'h5, q & 32'hD);
		chk("irq level", 32'h1, {31'h0, irq});
		wr(DTR_OFS_IRQ_STAT, 32'hF);
		rd(DTR_OFS_IRQ_STAT, q);
		chk("irq cleared", 32'h0, {31'h0, irq});
		// Stop command while the timer governs is flagged and ignored
		wr(DTR_OFS_CTRL, 32'h1);
		wr(DTR_OFS_CTRL, 32'h2);
		rd(DTR_OFS_STATUS, q);
		chk("still running", 32'h1, q);
		repeat (rt + 4) @(posedge core_clk);
		chk_cnt(rt);
		rd(DTR_OFS_IRQ_STAT, q);
		chk("illegal stop", 32'h9, q & 32'hD);
		// Zero run time: only the explicit stop ends the run
		wr(DTR_OFS_RUNTIME, 32'h0);
		wr(DTR_OFS_CTRL, 32'h1);
		repeat (300) @(posedge core_clk);
		rd(DTR_OFS_STATUS, q);
		chk("manual running", 32'h1, q);
		wr(DTR_OFS_CTRL, 32'h2);
		repeat (12) @(posedge core_clk);
		rd(DTR_OFS_STATUS, q);
		chk("manual stopped", 32'h0, q);
		wr(DTR_OFS_CNT_LO, 32'hFF);
		chk_cnt(304);
		u_dtr_ctrl_model.xfer(1'b0, 32'h100, 32'h0, q);
		chk("unmapped", 32'h0, q);
		// Start bit to an unmapped address must not alias onto the control word
		u_dtr_ctrl_model.xfer(1'b1, 32'h100, 32'h1, q);
		rd(DTR_OFS_STATUS, q);
		chk("unmapped start", 32'h0, q);
		// Thermal offsets, every code shift
		for (j = 0; j < 4; j++) begin
			raw = (j == 0) ? DTR_TEMP_HOT : 3'($urandom % 8);
			temp_raw <= raw;
			repeat (4) @(posedge core_clk);
			wr(DTR_OFS_TEMP, (32'(j) << 5) | 32'h7);
			repeat (2) @(posedge core_clk);
			rd(DTR_OFS_TEMP, q);
			chk("temp status", exp_temp(raw, 2'(j)), q);
			chk("refresh offset", 32'(j), {30'h0, temp_compensated_self_refresh_offset});
		end
		rd(DTR_OFS_IRQ_STAT, q);
		chk("temp sampled", 32'h2, q & 32'h2);
		raw = 3'($urandom % 8);
		temp_raw <= raw;
		repeat (70) @(posedge core_clk);
		rd(DTR_OFS_TEMP, q);
		chk("periodic sample", exp_temp(raw, 2'h3), q);
		raw = ~raw;
		temp_raw <= raw;
		lp_exit <= 1'b1;
		repeat (6) @(posedge core_clk);
		rd(DTR_OFS_TEMP, q);
		chk("exit sample", exp_temp(raw, 2'h3), q);
		lp_exit <= 1'b0;
		chk("response", 32'h0, {31'h0, hresp});
		end_of_test();
	end
endmodule : tb_dqs_osc_and_temp_status_readout
